// ==== inc/cpi_params.svh ====
// register offsets, field positions and reset values of the priority interface
`ifndef CPI_PARAMS_SVH
`define CPI_PARAMS_SVH

`define CPI_ADDR_W          8
`define CPI_OFS_CTRL        8'h00
`define CPI_OFS_PMR         8'h04
`define CPI_OFS_BPR         8'h08
`define CPI_OFS_ABPR        8'h0c
`define CPI_OFS_RUNNING     8'h10
`define CPI_OFS_HIGHEST     8'h14

`define CPI_CTRL_EN_GRP0    0
`define CPI_CTRL_EN_GRP1    1
`define CPI_CTRL_FAST_SEL   3
`define CPI_CTRL_COMMON_BINARY_POINT_SEL       4

`define CPI_HIGH_ID_LSB     8
`define CPI_HIGH_VALID      16

`define CPI_PMR_RST         8'h00
`define CPI_CTRL_RST        1'b0
`define CPI_IDLE_PRIO       8'hff
`define CPI_PRIO_FULL       8'hff
`define CPI_BP_NONE         3'h7

`endif

// ==== inc/cpi_pkg.sv ====
// types shared by the priority interface
package cpi_pkg;

  // one interrupt source as presented by the distributor
  typedef struct packed {
    logic       pending;
    logic       active;
    logic       group1;
    logic [7:0] prio;
  } cpi_src_t;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cpi_bus_req_t;

  // complete state of the interface
  typedef struct packed {
    logic        en_grp0;
    logic        en_grp1;
    logic        fast_sel;
    logic        common_binary_point_sel;
    logic [7:0]  pmr;
    logic [2:0]  bpr;
    logic [2:0]  abpr;
    logic [31:0] rdata;
    logic        irq;
    logic        fast_interrupt_request;
  } cpi_state_t;

endpackage : cpi_pkg

// ==== rtl/cpi_priority_iface.sv ====
// priority masking, grouping, preemption and irq/fiq routing of one processor interface
// How it works
// - signal only when pending priority is strictly below the mask value.
// - mask resets to zero, which blocks every interrupt.
// - mask compare uses the full implemented priority, no grouping.
// - the largest supported priority value is never signalled.
// - writing 255 to the mask stores the largest supported priority value.
// - equal group priority counts as equal for preemption.
// - preempt only when group priority is numerically below the running group priority.
// - with nothing active, best pending may be signalled, only the mask applies.
// - every candidate is checked against the mask as well.
// - binary point N keeps bits above N as group priority; 7 disables preemption.
// - binary point values below the minimum are raised to the minimum.
// - group 0 uses the binary point, group 1 the alias when common select is 0.
// - common select 1 makes group 1 use the group 0 binary point.
// - without grouping one binary point is always used.
// - lowest full priority wins within a group; ties go to the lowest index.
// - grouping gives separate irq and fast outputs; group 1 always goes to irq.
// - group 0 goes to irq or fast output by a software setting.
// - after reset only the single irq output is used.
// - lower numeric value means higher priority, zero is highest.
// - 4 to 8 priority bits; unimplemented low bits read zero, ignore writes.
// - the fast select bit picks irq or fast output for group 0.
`include "cpi_params.svh"

module cpi_priority_iface
  import cpi_pkg::*;
#(
  parameter int NUM_SRC   = 8,
  parameter int PRIO_BITS = 8,
  parameter int MIN_BP    = 0,
  parameter bit GROUPING  = 1'b1
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  // register port
  input  wire cpi_bus_req_t bus_i,
  output logic [31:0]       rdata_o,
  // interrupt sources from the distributor
  input  wire cpi_src_t     src_i [NUM_SRC],
  // requests to the processor
  output logic              irq_o,
  output logic              fiq_o
);

  localparam int ID_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

  localparam logic [7:0] IMPL_MASK = 8'(`CPI_PRIO_FULL << (8 - PRIO_BITS));
  localparam logic [2:0] MIN_BP_V  = 3'(MIN_BP);

  if (PRIO_BITS < 4 || PRIO_BITS > 8) begin : g_chk_bits
    $error("PRIO_BITS must be 4 to 8");
  end
  if (MIN_BP < 0 || MIN_BP > 3) begin : g_chk_bp
    $error("MIN_BP must be 0 to 3");
  end
  if (NUM_SRC < 1 || NUM_SRC > 256) begin : g_chk_src
    $error("NUM_SRC must be 1 to 256");
  end

  // group field mask for a binary point
  function automatic logic [7:0] group_mask(input logic [2:0] bp);
    logic [8:0] m;
    m = 9'h1fe << bp;
    return m[7:0];
  endfunction

  // clamp to the minimum supported point
  function automatic logic [2:0] clamp_bp(input logic [2:0] bp);
    return (bp < MIN_BP_V) ? MIN_BP_V : bp;
  endfunction

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  cpi_state_t state_reg;
  cpi_state_t state_next;

  // per source priority and group field
  logic [7:0] eff_prio [NUM_SRC];
  logic [7:0] grp_prio [NUM_SRC];
  logic       eligible [NUM_SRC];

  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    logic [2:0] bp_sel;
    always_comb begin
      if (GROUPING && src_i[i].group1 && !state_reg.common_binary_point_sel) begin
        bp_sel = state_reg.abpr;
      end else begin
        bp_sel = state_reg.bpr;
      end
    end
    // low bits of the priority are not implemented
    assign eff_prio[i] = src_i[i].prio & IMPL_MASK;
    assign grp_prio[i] = eff_prio[i] & group_mask(bp_sel);
    // group enables; without grouping the group 0 enable covers all
    assign eligible[i] = src_i[i].pending && !src_i[i].active &&
                         ((GROUPING && src_i[i].group1) ? state_reg.en_grp1 : state_reg.en_grp0);
  end

  logic            best_valid;
  logic [7:0]      best_prio;
  logic [7:0]      best_gp;
  logic [ID_W-1:0] best_id;
  logic            best_grp1;
  logic            run_idle;
  logic [7:0]      run_gp;
  logic            signal_ok;

  always_comb begin
    best_valid = 1'b0;
    best_prio  = `CPI_IDLE_PRIO;
    best_gp    = `CPI_IDLE_PRIO;
    best_id    = '0;
    best_grp1  = 1'b0;
    run_idle   = 1'b1;
    run_gp     = `CPI_IDLE_PRIO;
    for (int i = 0; i < NUM_SRC; i++) begin
      // lowest full value wins, strict compare keeps lowest index
      if (eligible[i] && (!best_valid || eff_prio[i] < best_prio)) begin
        best_valid = 1'b1;
        best_prio  = eff_prio[i];
        best_gp    = grp_prio[i];
        best_id    = ID_W'(i);
        best_grp1  = GROUPING && src_i[i].group1;
      end
      if (src_i[i].active && (run_idle || grp_prio[i] < run_gp)) begin
        run_idle = 1'b0;
        run_gp   = grp_prio[i];
      end
    end
  end

  always_comb begin
    signal_ok = best_valid;
    if (!(best_prio < state_reg.pmr)) begin
      signal_ok = 1'b0;
    end
    // largest supported value is always masked
    if (best_prio == IMPL_MASK) begin
      signal_ok = 1'b0;
    end
    if (!run_idle && !(best_gp < run_gp)) begin
      signal_ok = 1'b0;
    end
  end

  // read mux, unmapped reads return zero
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (bus_i.addr)
      `CPI_OFS_CTRL: begin
        rd_word[`CPI_CTRL_EN_GRP0] = state_reg.en_grp0;
        rd_word[`CPI_CTRL_EN_GRP1] = state_reg.en_grp1 & GROUPING;
        rd_word[`CPI_CTRL_FAST_SEL] = state_reg.fast_sel & GROUPING;
        rd_word[`CPI_CTRL_COMMON_BINARY_POINT_SEL]    = state_reg.common_binary_point_sel & GROUPING;
      end
      `CPI_OFS_PMR: begin
        rd_word[7:0] = state_reg.pmr;
      end
      `CPI_OFS_BPR: begin
        rd_word[2:0] = state_reg.bpr;
      end
      `CPI_OFS_ABPR: begin
        rd_word[2:0] = GROUPING ? state_reg.abpr : 3'h0;
      end
      `CPI_OFS_RUNNING: begin
        rd_word[7:0] = run_idle ? `CPI_IDLE_PRIO : run_gp;
      end
      `CPI_OFS_HIGHEST: begin
        rd_word[7:0] = best_prio;
        rd_word[`CPI_HIGH_ID_LSB +: ID_W] = best_id;
        rd_word[`CPI_HIGH_VALID] = best_valid;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    state_next       = state_reg;
    state_next.rdata = bus_i.rd ? rd_word : 32'h0000_0000;
    if (bus_i.wr) begin
      case (bus_i.addr)
        `CPI_OFS_CTRL: begin
          state_next.en_grp0  = bus_i.wdata[`CPI_CTRL_EN_GRP0];
          // routing bits exist only with grouping
          state_next.en_grp1  = bus_i.wdata[`CPI_CTRL_EN_GRP1] & GROUPING;
          state_next.fast_sel = bus_i.wdata[`CPI_CTRL_FAST_SEL] & GROUPING;
          state_next.common_binary_point_sel     = bus_i.wdata[`CPI_CTRL_COMMON_BINARY_POINT_SEL] & GROUPING;
        end
        `CPI_OFS_PMR: begin
          // low bits dropped, 255 lands on the largest value
          state_next.pmr = bus_i.wdata[7:0] & IMPL_MASK;
        end
        `CPI_OFS_BPR: begin
          state_next.bpr = clamp_bp(bus_i.wdata[2:0]);
        end
        `CPI_OFS_ABPR: begin
          if (GROUPING) begin
            state_next.abpr = clamp_bp(bus_i.wdata[2:0]);
          end
        end
        default: begin
        end
      endcase
    end
    // group 1 to irq, group 0 by fast select
    state_next.irq = signal_ok && (best_grp1 || !state_reg.fast_sel);
    state_next.fast_interrupt_request = signal_ok && !best_grp1 && state_reg.fast_sel;
  end

  always_ff @(posedge clock_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg.en_grp0  <= `CPI_CTRL_RST;
      state_reg.en_grp1  <= `CPI_CTRL_RST;
      state_reg.fast_sel <= `CPI_CTRL_RST;
      state_reg.common_binary_point_sel     <= `CPI_CTRL_RST;
      state_reg.pmr      <= `CPI_PMR_RST;
      state_reg.bpr      <= MIN_BP_V;
      state_reg.abpr     <= MIN_BP_V;
      state_reg.rdata    <= 32'h0000_0000;
      state_reg.irq      <= 1'b0;
      state_reg.fast_interrupt_request      <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_o = state_reg.rdata;
  assign irq_o   = state_reg.irq;
  assign fiq_o   = state_reg.fast_interrupt_request;

endmodule // cpi_priority_iface

// ==== dv/cpi_priority_iface_monitor.sv ====
// port-level assertions for the priority interface
`include "cpi_params.svh"

module cpi_priority_iface_monitor
  import cpi_pkg::*;
#(
  parameter int NUM_SRC   = 8,
  parameter int PRIO_BITS = 8
) (
  // clock and reset
  input wire logic         clock_i,
  input wire logic         resetn_i,
  // register port and sources
  input wire cpi_bus_req_t bus_i,
  input wire logic [31:0]  rdata_o,
  input wire cpi_src_t     src_i [NUM_SRC],
  // requests
  input wire logic         irq_o,
  input wire logic         fiq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] max_prio;
  logic [7:0] pmr_shadow_reg;
  logic       any_pend;
  logic       mask_cand;
  logic       cand;
  logic       g0_cand;
  logic       any_act;
  logic       fast_reg;
  assign max_prio = 8'hff << (8 - PRIO_BITS);
  always_comb begin
    cand = 1'b0;
    g0_cand = 1'b0;
    any_act = 1'b0;
    any_pend = 1'b0;
    mask_cand = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      any_act |= src_i[i].active;
      // highest valid also covers the never-signalled lowest priority
      any_pend |= src_i[i].pending && !src_i[i].active;
      if (src_i[i].pending && !src_i[i].active && (src_i[i].prio & max_prio) < pmr_shadow_reg) begin
        mask_cand = 1'b1;
      end
      if (src_i[i].pending && !src_i[i].active && (src_i[i].prio & max_prio) != max_prio) begin
        cand = 1'b1;
        g0_cand |= !src_i[i].group1;
      end
    end
  end
  // sticky: fast output may only follow a select write
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) fast_reg <= 1'b0;
    else if (bus_i.wr && bus_i.addr == `CPI_OFS_CTRL && bus_i.wdata[`CPI_CTRL_FAST_SEL]) fast_reg <= 1'b1;
  end
  // mask copy, taken on the same edge as the design takes the write
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pmr_shadow_reg <= 8'h00;
    end else if (bus_i.wr && bus_i.addr == `CPI_OFS_PMR) begin
      pmr_shadow_reg <= bus_i.wdata[7:0] & max_prio;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  AST_RDATA_IDLE: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0)
    else $error("read data not zero outside read");
  AST_RESET_QUIET: assert property ($rose(resetn_i) |-> (!irq_o && !fiq_o) [*4])
    else $error("request right after reset");
  AST_NO_CAND: assert property (!$past(cand) |-> !irq_o && !fiq_o)
    else $error("request without eligible source");
  AST_FIQ_GROUP0: assert property (fiq_o |-> $past(g0_cand))
    else $error("fast request without group 0 source");
  AST_ONE_OUTPUT: assert property (!(irq_o && fiq_o))
    else $error("both requests high");
  AST_SINGLE_OUT: assert property (!fast_reg |-> !fiq_o)
    else $error("fast request before select");
  AST_RUN_IDLE: assert property ($past(bus_i.rd && bus_i.addr == `CPI_OFS_RUNNING && !any_act) |-> rdata_o[7:0] == 8'hff)
    else $error("running priority not idle");
  AST_HIGH_NONE: assert property ($past(bus_i.rd && bus_i.addr == `CPI_OFS_HIGHEST && !any_pend) |-> !rdata_o[`CPI_HIGH_VALID])
    else $error("highest valid without candidate");
  AST_MASK_GATE: assert property ((irq_o || fiq_o) |-> $past(mask_cand))
    else $error("request without source above the mask");
  AST_MASK_ZERO: assert property ($past(pmr_shadow_reg == 8'h00) |-> !irq_o && !fiq_o)
    else $error("request while mask is zero");
endmodule // cpi_priority_iface_monitor

bind cpi_priority_iface cpi_priority_iface_monitor #(.NUM_SRC(NUM_SRC), .PRIO_BITS(PRIO_BITS))
  cpi_priority_iface_monitor_inst (.clock_i(clock_i), .resetn_i(resetn_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .src_i(src_i), .irq_o(irq_o), .fiq_o(fiq_o));

// ==== dv/cpi_core_model.sv ====
// processor core model counting interrupt entries
module cpi_core_model (
  // clock
  input  wire logic clock_i,
  // requests
  input  wire logic irq_i,
  input  wire logic fiq_i,
  // entries taken
  output logic [7:0] entries_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_reg = 1'b0;
  initial entries_o = 8'h00;
  always @(posedge clock_i) begin
    if ((irq_i || fiq_i) && !prev_reg) entries_o <= entries_o + 8'h01;
    prev_reg <= irq_i || fiq_i;
  end
endmodule // cpi_core_model

// ==== dv/testbench.sv ====
// self-checking bench for the priority interface
module testbench
  import cpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clock_i = 1'b0;
  logic         resetn_i = 1'b0;
  cpi_bus_req_t bus_i = '0;
  cpi_src_t     src_i [8];
  logic [31:0]  rdata_o;
  logic         irq_o;
  logic         fiq_o;
  logic [7:0]   entries;
  int           mismatches = 0;
  int           check_count = 0;
  cpi_priority_iface #(.NUM_SRC(8), .PRIO_BITS(5), .MIN_BP(2), .GROUPING(1'b1)) cpi_priority_iface_inst (
    .clock_i(clock_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .src_i(src_i), .irq_o(irq_o), .fiq_o(fiq_o));
  cpi_core_model cpi_core_model_inst (.clock_i(clock_i), .irq_i(irq_o), .fiq_i(fiq_o), .entries_o(entries));
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus_i.wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus_i.rd <= 1'b0;
    #1 chk("rdata_o", exp, rdata_o);
  endtask
  task automatic src(input int i, input logic p, input logic a, input logic g, input logic [7:0] pr);
    @(posedge clock_i);
    src_i[i] <= '{pending: p, active: a, group1: g, prio: pr};
  endtask
  // two cycles of latency after a write, one after a source change
  task automatic req_is(input logic ei, input logic ef);
    repeat (3) @(posedge clock_i);
    #1 chk("irq_o", {31'h0, ei}, {31'h0, irq_o});
    chk("fiq_o", {31'h0, ef}, {31'h0, fiq_o});
  endtask
  task automatic t_reset;
    rdchk(8'h04, 32'h0);
    rdchk(8'h00, 32'h0);
    rdchk(8'h10, 32'hff);
    rdchk(8'h20, 32'h0);
  endtask
  task automatic t_mask;
    wr(8'h00, 32'h1);
    src(0, 1'b1, 1'b0, 1'b0, 8'h40);
    req_is(1'b0, 1'b0);
    wr(8'h04, 32'h48);
    req_is(1'b1, 1'b0);
    wr(8'h04, 32'h40);
    req_is(1'b0, 1'b0);
    wr(8'h08, 32'h5);
    wr(8'h04, 32'h50);
    src(0, 1'b1, 1'b0, 1'b0, 8'h48);
    req_is(1'b1, 1'b0);
    wr(8'h04, 32'hff);
    rdchk(8'h04, 32'hf8);
    src(0, 1'b1, 1'b0, 1'b0, 8'hf8);
    req_is(1'b0, 1'b0);
  endtask
  task automatic t_pre;
    src(1, 1'b0, 1'b1, 1'b0, 8'h50);
    src(0, 1'b1, 1'b0, 1'b0, 8'h40);
    wr(8'h08, 32'h3);
    req_is(1'b1, 1'b0);
    wr(8'h08, 32'h4);
    req_is(1'b0, 1'b0);
    rdchk(8'h10, 32'h40);
    wr(8'h08, 32'h7);
    req_is(1'b0, 1'b0);
    src(2, 1'b1, 1'b0, 1'b0, 8'h48);
    src(1, 1'b0, 1'b0, 1'b0, 8'h50);
    req_is(1'b1, 1'b0);
    rdchk(8'h14, 32'h0001_0040);
    wr(8'h08, 32'h0);
    rdchk(8'h08, 32'h2);
  endtask
  task automatic t_route;
    wr(8'h00, 32'h9);
    req_is(1'b0, 1'b1);
    src(0, 1'b1, 1'b0, 1'b1, 8'h40);
    src(2, 1'b0, 1'b0, 1'b0, 8'h48);
    wr(8'h00, 32'hb);
    req_is(1'b1, 1'b0);
    src(1, 1'b0, 1'b1, 1'b1, 8'h50);
    wr(8'h08, 32'h4);
    wr(8'h0c, 32'h3);
    wr(8'h00, 32'h2);
    req_is(1'b1, 1'b0);
    wr(8'h00, 32'h12);
    req_is(1'b0, 1'b0);
    // two entries in t_mask, two in t_pre, one here; the irq to fiq handover is seamless
    chk("entries_o", 32'h5, {24'h0, entries});
  endtask
  // a mid-run reset drops the fast output and the routing setup
  task automatic t_reset2;
    src(1, 1'b0, 1'b0, 1'b0, 8'h50);
    src(0, 1'b1, 1'b0, 1'b0, 8'h40);
    wr(8'h00, 32'h9);
    req_is(1'b0, 1'b1);
    @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    req_is(1'b0, 1'b0);
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h0);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    finish_test;
  end
  initial begin
    for (int i = 0; i < 8; i++) src_i[i] = '0;
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_reset;
    t_mask;
    t_pre;
    t_route;
    t_reset2;
    finish_test;
  end
endmodule // testbench
